/* safr_pkg.sv */
package safr_pkg;
  // ==========================================================
  // widths and counts
  localparam int          DATA_W      = 16;
  localparam int          ADDR_W      = 8;
  localparam int          N_HASH      = 4;
  localparam int          N_SA        = 3;
  localparam int          N_WORDS     = N_HASH + N_SA;
  localparam int          IDX_W       = 3;
  localparam int          EE_IDX_W    = 2;

  // ==========================================================
  // register byte addresses (one aligned word each)
  localparam logic [7:0]  A_HASH0     = 8'h20;
  localparam logic [7:0]  A_HASH1     = 8'h24;
  localparam logic [7:0]  A_HASH2     = 8'h28;
  localparam logic [7:0]  A_HASH3     = 8'h2c;
  localparam logic [7:0]  A_SA_LOW    = 8'h30;
  localparam logic [7:0]  A_SA_MID    = 8'h34;
  localparam logic [7:0]  A_SA_HIGH   = 8'h38;
  localparam logic [7:0]  A_EE_CTRL   = 8'h4c;
  localparam logic [7:0]  A_STATUS    = 8'h50;

  // word index of the first station-address word
  localparam logic [2:0]  SA_BASE_IDX = 3'h4;

  // ==========================================================
  // field positions
  localparam int          EE_RELOAD_BIT = 14;
  localparam int          ST_STOPPED    = 0;
  localparam int          ST_SUSPENDED  = 1;
  localparam int          ST_EE_BUSY    = 2;
  localparam int          ST_EE_PRESENT = 3;

  // ==========================================================
  // reset values
  localparam logic [31:0] PRDATA_RST  = 32'h0000_0000;
  localparam logic        BOOT_RST    = 1'b1;
endpackage

/* safr_word.sv */
`timescale 1ns/1ps
module safr_word
  import safr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              a_valid,
  input  wire logic [DATA_W-1:0] a_data,
  input  wire logic              b_valid,
  input  wire logic [DATA_W-1:0] b_data,
  input  wire logic              c_valid,
  input  wire logic [DATA_W-1:0] c_data,
  output logic      [DATA_W-1:0] q
);
  logic [DATA_W-1:0] data_ff;

  // no reset on purpose: stored contents survive every reset
  always_ff @(posedge clk) begin
    if (a_valid) begin
      data_ff <= a_data;
    end else if (b_valid) begin
      data_ff <= b_data;
    end else if (c_valid) begin
      data_ff <= c_data;
    end
  end

  assign q = data_ff;
endmodule // safr_word

/* safr_ee_loader.sv */
`timescale 1ns/1ps
module safr_ee_loader
  import safr_pkg::*;
#(
  parameter int N = N_SA
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                start,
  input  wire logic                present,
  output logic                     rd_req,
  output logic      [EE_IDX_W-1:0] rd_addr,
  input  wire logic                rd_ack,
  input  wire logic [DATA_W-1:0]   rd_data,
  output logic                     ld_valid,
  output logic      [EE_IDX_W-1:0] ld_index,
  output logic      [DATA_W-1:0]   ld_data,
  output logic                     busy
);
  typedef enum logic {SAFR_EE_IDLE, SAFR_EE_FETCH} safr_ee_state_t;

  safr_ee_state_t      state_ff;
  logic [EE_IDX_W-1:0] idx_ff;
  logic                ld_valid_ff;
  logic [EE_IDX_W-1:0] ld_index_ff;
  logic [DATA_W-1:0]   ld_data_ff;

  initial begin
    if (N < 1 || N > (1 << EE_IDX_W)) begin
      $error("safr_ee_loader: N out of range");
    end
  end

  // ==========================================================
  // fetch sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SAFR_EE_IDLE;
      idx_ff   <= '0;
    end else begin
      unique case (state_ff)
        SAFR_EE_IDLE: begin
          // absent part: nothing to fetch, contents stay as they were
          if (start && present) begin
            state_ff <= SAFR_EE_FETCH;
            idx_ff   <= '0;
          end
        end
        SAFR_EE_FETCH: begin
          if (rd_ack) begin
            idx_ff <= idx_ff + 1'b1;
            if (idx_ff == EE_IDX_W'(N - 1)) begin
              state_ff <= SAFR_EE_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ld_valid_ff <= 1'b0;
      ld_index_ff <= '0;
      ld_data_ff  <= '0;
    end else begin
      ld_valid_ff <= (state_ff == SAFR_EE_FETCH) && rd_ack;
      if ((state_ff == SAFR_EE_FETCH) && rd_ack) begin
        ld_index_ff <= idx_ff;
        ld_data_ff  <= rd_data;
      end
    end
  end

  assign rd_req   = (state_ff == SAFR_EE_FETCH);
  assign rd_addr  = idx_ff;
  assign busy     = (state_ff == SAFR_EE_FETCH) || ld_valid_ff;
  assign ld_valid = ld_valid_ff;
  assign ld_index = ld_index_ff;
  assign ld_data  = ld_data_ff;
endmodule // safr_ee_loader

/* safr_regs.sv */
// What this block does
// - upper sixteen bits written as zero by host; device reads them back as zero
// - 64-bit hash filter kept in four 16-bit words, low word first
// - hash words undefined until init-block load or direct host write
// - filter and address words accessible only while stopped or suspended
// - stored words unchanged by software reset or stop; hardware reset keeps hash words, and station words only without a serial prom
// - 48-bit station address kept in three 16-bit words, low word first
// - station address fetched from serial prom after reset and on reload command
// - without a serial prom the station address stays undefined until loaded
// - station address also loadable from init block and by host write
`timescale 1ns/1ps
module safr_regs
  import safr_pkg::*;
#(
  parameter int HASH_WORDS = N_HASH,
  parameter int SA_WORDS   = N_SA
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     stopped_flag,
  input  wire logic                     suspended_flag,
  input  wire logic                     init_load_valid,
  input  wire logic [IDX_W-1:0]         init_load_index,
  input  wire logic [DATA_W-1:0]        init_load_data,
  input  wire logic                     ee_present,
  output logic                          ee_rd_req,
  output logic      [EE_IDX_W-1:0]      ee_rd_addr,
  input  wire logic                     ee_rd_ack,
  input  wire logic [DATA_W-1:0]        ee_rd_data,
  output logic                          ee_load_busy,
  output logic      [DATA_W*N_HASH-1:0] multicast_hash_filter,
  output logic      [DATA_W*N_SA-1:0]   station_address
);
  // ==========================================================
  // elaboration checks
  initial begin
    if (HASH_WORDS != N_HASH || SA_WORDS != N_SA) begin
      $error("safr_regs: word counts fixed by the address map");
    end
  end

  // ==========================================================
  // address decode
  function automatic logic word_hit(input logic [ADDR_W-1:0] a);
    word_hit = (a[1:0] == 2'b00) && (a >= A_HASH0) && (a <= A_SA_HIGH);
  endfunction

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off      = a - A_HASH0;
    word_idx = off[IDX_W+1:2];
  endfunction

  logic                     setup_ph;
  logic                     access_ph;
  logic                     allowed;
  logic                     hit_word;
  logic                     hit_ctrl;
  logic                     hit_stat;
  logic                     mapped;
  logic                     denied;
  logic                     host_wr;
  logic [IDX_W-1:0]         widx;
  logic [31:0]              nxt_prdata;
  logic [31:0]              prdata_ff;
  logic [DATA_W-1:0]        words [N_WORDS];
  logic                     boot_ff;
  logic                     reload_ff;
  logic                     ee_start;
  logic                     ee_ld_valid;
  logic [EE_IDX_W-1:0]      ee_ld_index;
  logic [DATA_W-1:0]        ee_ld_data;
  logic [IDX_W-1:0]         ee_word_idx;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign allowed   = stopped_flag || suspended_flag;
  assign hit_word  = word_hit(paddr);
  assign widx      = word_idx(paddr);
  assign hit_ctrl  = (paddr == A_EE_CTRL);
  assign hit_stat  = (paddr == A_STATUS);
  assign mapped    = hit_word || hit_ctrl || hit_stat;
  // filter words refuse any access outside the stopped/suspended window
  assign denied    = hit_word && !allowed;
  // only an accepted access phase may touch storage
  assign host_wr   = access_ph && pwrite && hit_word && allowed;

  // ==========================================================
  // apb answer: zero wait states, read data captured in setup
  assign pready  = 1'b1;
  assign pslverr = access_ph && (!mapped || denied);

  always_comb begin
    nxt_prdata = '0;
    if (hit_word && allowed) begin
      // upper half always reads as zero
      nxt_prdata = {16'h0000, words[widx]};
    end else if (hit_ctrl) begin
      nxt_prdata[EE_RELOAD_BIT] = ee_load_busy;
    end else if (hit_stat) begin
      nxt_prdata[ST_STOPPED]    = stopped_flag;
      nxt_prdata[ST_SUSPENDED]  = suspended_flag;
      nxt_prdata[ST_EE_BUSY]    = ee_load_busy;
      nxt_prdata[ST_EE_PRESENT] = ee_present;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= PRDATA_RST;
    end else if (setup_ph && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // ==========================================================
  // serial prom fetch: once after reset release, again on command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_ff <= BOOT_RST;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_ff <= 1'b0;
    end else begin
      // self-clearing command bit
      reload_ff <= access_ph && pwrite && hit_ctrl
                   && pwdata[EE_RELOAD_BIT];
    end
  end

  assign ee_start = boot_ff || reload_ff;

  safr_ee_loader #(
    .N        (N_SA)
  ) u_ee (
    .clk      (pclk),
    .rstn     (presetn),
    .start    (ee_start),
    .present  (ee_present),
    .rd_req   (ee_rd_req),
    .rd_addr  (ee_rd_addr),
    .rd_ack   (ee_rd_ack),
    .rd_data  (ee_rd_data),
    .ld_valid (ee_ld_valid),
    .ld_index (ee_ld_index),
    .ld_data  (ee_ld_data),
    .busy     (ee_load_busy)
  );

  assign ee_word_idx = SA_BASE_IDX + IDX_W'(ee_ld_index);

  // ==========================================================
  // storage words: init block first, then prom, then host
  // a host write that meets a hardware load of the same word in the same cycle is lost;
  // software only writes while stopped or suspended, when no load should be running
  for (genvar i = 0; i < N_WORDS; i++) begin : g_word
    logic init_hit;
    logic ee_hit;
    logic host_hit;
    assign init_hit = init_load_valid && (init_load_index == IDX_W'(i));
    assign ee_hit   = (i >= N_HASH) && ee_ld_valid
                      && (ee_word_idx == IDX_W'(i));
    assign host_hit = host_wr && (widx == IDX_W'(i));
    safr_word u_word (
      .clk     (pclk),
      .a_valid (init_hit),
      .a_data  (init_load_data),
      .b_valid (ee_hit),
      .b_data  (ee_ld_data),
      .c_valid (host_hit),
      .c_data  (pwdata[DATA_W-1:0]),
      .q       (words[i])
    );
  end

  // low word at the lowest address
  for (genvar h = 0; h < N_HASH; h++) begin : g_hash
    assign multicast_hash_filter[h*DATA_W +: DATA_W] = words[h];
  end

  for (genvar s = 0; s < N_SA; s++) begin : g_sa
    assign station_address[s*DATA_W +: DATA_W] = words[N_HASH + s];
  end

  // ==========================================================
  // checks
  sequence host_wr_seq(logic [ADDR_W-1:0] a);
    access_ph && pwrite && paddr == a && allowed
    && !init_load_valid && !ee_ld_valid;
  endsequence

  sequence reload_cmd_seq;
    access_ph && pwrite && hit_ctrl && pwdata[EE_RELOAD_BIT]
    && !ee_load_busy && ee_present;
  endsequence

  chk_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_word) |=> (prdata[31:16] == 16'h0000)
  ) else $error("upper half of a filter word read non-zero");

  chk_hash_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr_seq(A_HASH0) |=> (multicast_hash_filter[15:0] == $past(pwdata[15:0]))
  ) else $error("hash word 0 not in filter bits 15:0");

  chk_hash_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr_seq(A_HASH3) |=> (multicast_hash_filter[63:48] == $past(pwdata[15:0]))
  ) else $error("hash word 3 not in filter bits 63:48");

  chk_init_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    (init_load_valid && init_load_index == 3'h2)
    |=> (multicast_hash_filter[47:32] == $past(init_load_data))
  ) else $error("init block load missed hash word 2");

  chk_deny_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && hit_word && !stopped_flag && !suspended_flag) |-> pslverr
  ) else $error("filter access outside stop/suspend not refused");

  chk_hold_value: assert property (
    @(posedge pclk)
    (!host_wr && !init_load_valid && !ee_ld_valid)
    |=> $stable(station_address) && $stable(multicast_hash_filter)
  ) else $error("stored word changed with no load");

  chk_sa_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr_seq(A_SA_HIGH) |=> (station_address[47:32] == $past(pwdata[15:0]))
  ) else $error("station word 2 not in address bits 47:32");

  chk_reload_run: assert property (
    @(posedge pclk) disable iff (!presetn)
    reload_cmd_seq ##1 1'b1 |=> ee_rd_req
  ) else $error("reload command did not start the prom fetch");

  chk_boot_fetch: assert property (
    @(posedge pclk) disable iff (!presetn)
    (boot_ff && ee_present) |=> ee_rd_req
  ) else $error("no prom fetch after reset release");

  chk_no_prom: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ee_start && !ee_present && !ee_load_busy) |=> !ee_rd_req [*2]
  ) else $error("prom fetch started with no prom present");

  chk_sa_init: assert property (
    @(posedge pclk) disable iff (!presetn)
    (init_load_valid && init_load_index == SA_BASE_IDX)
    |=> (station_address[15:0] == $past(init_load_data))
  ) else $error("init block load missed station word 0");

  chk_denied_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && pwrite && hit_word && !allowed
     && !init_load_valid && !ee_ld_valid)
    |=> $stable(station_address) && $stable(multicast_hash_filter)
  ) else $error("write outside stop/suspend changed a word");

  chk_hash_mid: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr_seq(A_HASH1) |=> (multicast_hash_filter[31:16] == $past(pwdata[15:0]))
  ) else $error("hash word 1 not in filter bits 31:16");

  chk_hash_third: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr_seq(A_HASH2) |=> (multicast_hash_filter[47:32] == $past(pwdata[15:0]))
  ) else $error("hash word 2 not in filter bits 47:32");

  chk_sa_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr_seq(A_SA_LOW) |=> (station_address[15:0] == $past(pwdata[15:0]))
  ) else $error("station word 0 not in address bits 15:0");

  chk_sa_mid: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr_seq(A_SA_MID) |=> (station_address[31:16] == $past(pwdata[15:0]))
  ) else $error("station word 1 not in address bits 31:16");

  chk_deny_rdata: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_word && !allowed) |=> (prdata == 32'h0000_0000)
  ) else $error("refused filter read returned data");

  chk_grant_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && hit_word && allowed) |-> !pslverr
  ) else $error("filter access while stopped or suspended refused");

  // ==========================================================
  // prom fetch steps: one word per acknowledge, stored a cycle later
  sequence prom_beat_seq;
    ee_rd_req && ee_rd_ack;
  endsequence

  // a same-cycle init-block load wins, so it must be absent here
  sequence prom_store_seq(logic [EE_IDX_W-1:0] k);
    ee_ld_valid && ee_ld_index == k && !init_load_valid;
  endsequence

  chk_prom_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    prom_beat_seq |=> (ee_ld_valid && ee_load_busy)
  ) else $error("prom word acknowledged but not stored");

  chk_prom_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ee_rd_req && ee_rd_ack && ee_rd_addr != EE_IDX_W'(N_SA - 1))
    |=> (ee_rd_req && ee_rd_addr == $past(ee_rd_addr) + 2'h1)
  ) else $error("prom fetch did not move to the next word");

  chk_prom_done: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ee_rd_req && ee_rd_ack && ee_rd_addr == EE_IDX_W'(N_SA - 1))
    |=> !ee_rd_req
  ) else $error("prom fetch ran past the last station word");

  chk_prom_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    prom_store_seq(2'h0)
    |=> (station_address[15:0] == $past(ee_ld_data))
  ) else $error("prom word 0 not in address bits 15:0");

  chk_prom_mid: assert property (
    @(posedge pclk) disable iff (!presetn)
    prom_store_seq(2'h1)
    |=> (station_address[31:16] == $past(ee_ld_data))
  ) else $error("prom word 1 not in address bits 31:16");
endmodule // safr_regs

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import safr_pkg::*;
;
  // ==========================================================
  // signals
  logic                     pclk            = 1'b0;
  logic                     presetn         = 1'b0;
  logic                     psel            = 1'b0;
  logic                     penable         = 1'b0;
  logic                     pwrite          = 1'b0;
  logic [ADDR_W-1:0]        paddr           = 8'h00;
  logic [31:0]              pwdata          = 32'h0000_0000;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     stopped_flag    = 1'b1;
  logic                     suspended_flag  = 1'b0;
  logic                     init_load_valid = 1'b0;
  logic [IDX_W-1:0]         init_load_index = 3'h0;
  logic [DATA_W-1:0]        init_load_data  = 16'h0000;
  logic                     ee_present      = 1'b1;
  logic                     ee_rd_req;
  logic [EE_IDX_W-1:0]      ee_rd_addr;
  logic                     ee_rd_ack       = 1'b0;
  logic [DATA_W-1:0]        ee_rd_data      = 16'h5a5a;
  logic                     ee_load_busy;
  logic [DATA_W*N_HASH-1:0] multicast_hash_filter;
  logic [DATA_W*N_SA-1:0]   station_address;
  logic [DATA_W-1:0]        rom [3];
  logic [1:0]               dly_cnt         = 2'h0;
  logic [31:0]              rd_val;
  logic                     rd_err;
  logic                     req_seen;
  int                       error_cnt       = 0;
  int                       compares        = 0;

  typedef struct {logic [7:0] addr; logic [15:0] data;} safr_row_t;
  safr_row_t rows [N_WORDS] = '{'{A_HASH0, 16'h1101}, '{A_HASH1, 16'h2202},
    '{A_HASH2, 16'h4404}, '{A_HASH3, 16'h8808}, '{A_SA_LOW, 16'hfedc},
    '{A_SA_MID, 16'h0001}, '{A_SA_HIGH, 16'h8000}};

  safr_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stopped_flag(stopped_flag), .suspended_flag(suspended_flag),
    .init_load_valid(init_load_valid), .init_load_index(init_load_index),
    .init_load_data(init_load_data), .ee_present(ee_present), .ee_rd_req(ee_rd_req),
    .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data),
    .ee_load_busy(ee_load_busy), .multicast_hash_filter(multicast_hash_filter),
    .station_address(station_address));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // serial prom stand-in: answer after a delay that grows with the word index
  always @(posedge pclk) begin
    if (ee_rd_req && !ee_rd_ack && dly_cnt >= ee_rd_addr) begin
      ee_rd_ack  <= 1'b1;
      ee_rd_data <= rom[ee_rd_addr];
      dly_cnt    <= 2'h0;
    end else begin
      ee_rd_ack  <= 1'b0;
      // data not valid outside ack: keep it toggling so stale values show up
      ee_rd_data <= ~ee_rd_data;
      if (ee_rd_req && !ee_rd_ack) begin
        dly_cnt <= dly_cnt + 2'h1;
      end
    end
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit here: the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_chk(input logic [7:0] addr, input logic [31:0] wd, input logic exp_err);
    apb(1'b1, addr, wd, rd_val, rd_err);
    chk_val("write error", 64'(exp_err), 64'(rd_err));
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, addr, 32'h0000_0000, rd_val, rd_err);
    chk_val("read error", 64'(exp_err), 64'(rd_err));
    chk_val("read data", 64'(exp), 64'(rd_val));
  endtask

  task automatic wait_prom();
    int n;
    n = 0;
    while (ee_load_busy !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk_val("prom busy", 64'h1, 64'(ee_load_busy));
    n = 0;
    while (ee_load_busy !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk_val("prom idle", 64'h0, 64'(ee_load_busy));
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    rom[0] = 16'h3412;
    rom[1] = 16'h7856;
    rom[2] = 16'hbc9a;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_prom();
    chk_val("station after boot", 64'({rom[2], rom[1], rom[0]}), 64'(station_address));
    rd_chk(A_SA_MID, {16'h0, rom[1]}, 1'b0);
    // every word written while stopped, then read back
    foreach (rows[i]) begin
      wr_chk(rows[i].addr, {16'h0, rows[i].data}, 1'b0);
      rd_chk(rows[i].addr, {16'h0, rows[i].data}, 1'b0);
    end
    chk_val("hash", {rows[3].data, rows[2].data, rows[1].data, rows[0].data},
            multicast_hash_filter);
    chk_val("station", 64'({rows[6].data, rows[5].data, rows[4].data}),
            64'(station_address));
    rd_chk(8'h60, 32'h0, 1'b1);
    rd_chk(A_STATUS, 32'h0000_0009, 1'b0);
    // neither flag: access refused, contents kept
    stopped_flag <= 1'b0;
    wr_chk(A_HASH1, 32'h0000_dead, 1'b1);
    wr_chk(A_SA_HIGH, 32'h0000_beef, 1'b1);
    rd_chk(A_HASH1, 32'h0, 1'b1);
    suspended_flag <= 1'b1;
    rd_chk(A_HASH1, {16'h0, rows[1].data}, 1'b0);
    rd_chk(A_SA_HIGH, {16'h0, rows[6].data}, 1'b0);
    wr_chk(A_HASH3, 32'h0000_0f0f, 1'b0);
    rows[3].data = 16'h0f0f;
    // init-block loads, one hash and one station word
    @(posedge pclk);
    init_load_valid <= 1'b1;
    init_load_index <= 3'h2;
    init_load_data  <= 16'hc3c3;
    @(posedge pclk);
    init_load_index <= 3'h4;
    init_load_data  <= 16'h5aa5;
    @(posedge pclk);
    init_load_valid <= 1'b0;
    @(posedge pclk);
    rows[2].data = 16'hc3c3;
    rows[4].data = 16'h5aa5;
    chk_val("hash init", {rows[3].data, rows[2].data, rows[1].data, rows[0].data},
            multicast_hash_filter);
    chk_val("station init", 64'({rows[6].data, rows[5].data, rows[4].data}),
            64'(station_address));
    // reset in mid-run with no prom: contents kept, no fetch started
    ee_present <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    req_seen = 1'b0;
    repeat (12) begin
      @(posedge pclk);
      if (ee_rd_req !== 1'b0) req_seen = 1'b1;
    end
    chk_val("fetch without prom", 64'h0, 64'(req_seen));
    chk_val("hash kept", {rows[3].data, rows[2].data, rows[1].data, rows[0].data},
            multicast_hash_filter);
    chk_val("station kept", 64'({rows[6].data, rows[5].data, rows[4].data}),
            64'(station_address));
    // reload command with a prom fitted and new contents
    ee_present <= 1'b1;
    rom[0] = 16'h00ff;
    rom[1] = 16'hff00;
    rom[2] = 16'h0110;
    wr_chk(A_EE_CTRL, 32'h1 << EE_RELOAD_BIT, 1'b0);
    wait_prom();
    chk_val("station reload", 64'({rom[2], rom[1], rom[0]}), 64'(station_address));
    rd_chk(A_SA_LOW, {16'h0, rom[0]}, 1'b0);
    rd_chk(A_HASH2, {16'h0, rows[2].data}, 1'b0);
    conclude();
  end
endmodule // tb_top
